// File: src/evlog_pkg.sv
package evlog_pkg;

    // Largest number of monitored inputs a logger instance can serve.
    localparam int EVLOG_MAX_INPUTS   = 8;
    // Entries in the shared message table.
    localparam int EVLOG_MSG_ENTRIES  = 64;
    // Width of a message identifier.
    localparam int EVLOG_MSG_ID_W     = 6;
    // Longest message text in characters.
    localparam int EVLOG_MSG_MAX_CHARS = 32767;
    // Width of a message text length field.
    localparam int EVLOG_MSG_LEN_W    = 15;
    // Width of an input index.
    localparam int EVLOG_IDX_W        = 3;
    // Width of an instance (block) index.
    localparam int EVLOG_BLK_W        = 8;
    // Depth of the history entry queue.
    localparam int EVLOG_QUEUE_DEPTH  = 8;

    // Edge condition encodings of each input.
    typedef enum logic [1:0] {
        EVLOG_EDGE_RISE = 2'h1,
        EVLOG_EDGE_FALL = 2'h2,
        EVLOG_EDGE_BOTH = 2'h3
    } evlog_edge_t;

    // One diagnostics history entry.
    typedef struct packed {
        logic [EVLOG_BLK_W-1:0]    blk;     // Instance index.
        logic [EVLOG_IDX_W-1:0]    input_n; // Input number.
        logic [EVLOG_MSG_ID_W-1:0] msg_id;  // Message identifier.
        logic [EVLOG_MSG_LEN_W-1:0] msg_len; // Message text length.
    } evlog_entry_t;

    // One shared-table write request.
    typedef struct packed {
        logic                       we;   // Write strobe.
        logic [EVLOG_MSG_ID_W-1:0]  id;   // Entry written.
        logic [EVLOG_MSG_LEN_W-1:0] len;  // Text length in characters.
    } evlog_tbl_wr_t;

endpackage

// File: src/evlog_msg_table.sv
`timescale 1ns/1ns
// Shared message table: one length word per message identifier.
module evlog_msg_table
    import evlog_pkg::*;
(
    input  wire logic                       i_core_clk, // Clock.
    input  wire evlog_tbl_wr_t              i_wr,       // Write request.
    input  wire logic [EVLOG_MSG_ID_W-1:0]  i_rd_id,    // Read identifier.
    output logic      [EVLOG_MSG_LEN_W-1:0] o_rd_len    // Registered length.
);

    // Storage array; contents survive controller reset.
    logic [EVLOG_MSG_LEN_W-1:0] mem_q [EVLOG_MSG_ENTRIES];

    // Write port.
    always_ff @(posedge i_core_clk) begin
        if (i_wr.we) begin
            mem_q[i_wr.id] <= i_wr.len;
        end
    end

    // Registered read port.
    always_ff @(posedge i_core_clk) begin
        o_rd_len <= mem_q[i_rd_id];
    end

endmodule

// File: src/evlog_logger.sv
`timescale 1ns/1ns
module evlog_logger
    import evlog_pkg::*;
#(
    parameter int NUM_INPUTS = EVLOG_MAX_INPUTS, // Used inputs.
    parameter int BLK_INDEX  = 0                 // Instance index.
) (
    input  wire logic                      i_core_clk, // Clock.
    input  wire logic                      i_reset,    // Sync reset.
    input  wire logic [NUM_INPUTS-1:0]     i_sig,      // Monitored inputs.
    input  wire evlog_edge_t [NUM_INPUTS-1:0] i_edge_cfg, // Edge per input.
    input  wire logic [NUM_INPUTS-1:0][EVLOG_MSG_ID_W-1:0] i_msg_cfg, // IDs.
    input  wire evlog_tbl_wr_t             i_tbl_wr,   // Table write.
    input  wire logic                      i_hist_ready, // History accepts.
    input  wire logic                      i_lower_busy, // Lower blk pending.
    output logic      [NUM_INPUTS-1:0]     o_pulse,    // Edge pulses.
    output logic                           o_hist_valid, // Entry valid.
    output evlog_entry_t                   o_hist_entry, // Entry data.
    output logic                           o_busy,     // Entries pending.
    output logic                           o_overflow  // Entry was lost.
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    // Only one to eight inputs can be served.
    if (NUM_INPUTS < 1 || NUM_INPUTS > EVLOG_MAX_INPUTS) begin : g_bad_n
        $error("NUM_INPUTS must lie between one and eight");
    end
    // Instance index must fit the entry field.
    if (BLK_INDEX < 0 || BLK_INDEX >= (1 << EVLOG_BLK_W)) begin : g_bad_b
        $error("BLK_INDEX does not fit the entry field");
    end
    // Queue pointers wrap by overflow, so the depth must be a power of two.
    if ((EVLOG_QUEUE_DEPTH & (EVLOG_QUEUE_DEPTH - 1)) != 0) begin : g_bad_q
        $error("EVLOG_QUEUE_DEPTH must be a power of two");
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection.

    logic [NUM_INPUTS-1:0] prev_q;   // Previous-cycle samples.
    logic                  primed_q; // Previous samples are valid.
    logic [NUM_INPUTS-1:0] hit;      // Qualifying edges this cycle.

    // Capture samples; the first cycle after reset preloads them.
    // Inputs are synchronous to the clock, so they are taken as they stand.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            prev_q   <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= i_sig;
            primed_q <= 1'b1;
        end
    end

    // Each input is judged on its own edge condition.
    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_edge
        logic rise;  // Low to high.
        logic fall;  // High to low.
        logic hit_g; // This input qualifies.
        assign rise = primed_q && i_sig[g] && !prev_q[g];
        assign fall = primed_q && !i_sig[g] && prev_q[g];
        always_comb begin
            unique case (i_edge_cfg[g])
                EVLOG_EDGE_RISE: hit_g = rise;
                EVLOG_EDGE_FALL: hit_g = fall;
                EVLOG_EDGE_BOTH: hit_g = rise | fall;
                default:         hit_g = 1'b0; // Code zero: never fires.
            endcase
        end
        // Each bit of the hit vector has this one driver.
        assign hit[g] = hit_g;
    end

    // One-cycle output pulse per qualifying edge.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_pulse <= '0;
        end else begin
            o_pulse <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry queue, filled lowest input first.

    localparam int PW = $clog2(EVLOG_QUEUE_DEPTH + 1); // Count width.
    localparam int AW = $clog2(EVLOG_QUEUE_DEPTH);     // Address width.

    typedef struct packed {
        logic [EVLOG_IDX_W-1:0]    input_n; // Input number.
        logic [EVLOG_MSG_ID_W-1:0] msg_id;  // Message identifier.
    } evlog_qent_t;

    evlog_qent_t             q_mem_q [EVLOG_QUEUE_DEPTH]; // Queue storage.
    logic [AW-1:0]           wr_ptr_q;  // Write address.
    logic [AW-1:0]           rd_ptr_q;  // Read address.
    logic [PW-1:0]           count_q;   // Filled entries.
    logic                    pop;       // Entry handed to table lookup.
    logic                    out_busy_q; // Lookup stage holds an entry.

    // Queue is drained only when the lookup stage is free.
    // Only one entry is in flight between the queue and the history port.
    assign pop = (count_q != '0) && !out_busy_q;

    // Push every hit in ascending input order, dropping only when full.
    // A hit that finds the queue full is lost and flagged for one cycle.
    always_ff @(posedge i_core_clk) begin
        logic [AW-1:0] wp;  // Running write address.
        logic [PW-1:0] cnt; // Running count.
        logic          ovf; // Drop seen this cycle.
        wp  = wr_ptr_q;
        cnt = count_q - PW'(pop);
        ovf = 1'b0;
        if (i_reset) begin
            wr_ptr_q   <= '0;
            count_q    <= '0;
            o_overflow <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (hit[i]) begin
                    if (cnt < PW'(EVLOG_QUEUE_DEPTH)) begin
                        q_mem_q[wp] <= '{EVLOG_IDX_W'(i), i_msg_cfg[i]};
                        wp  = AW'(wp + 1'b1);
                        cnt = cnt + 1'b1;
                    end else begin
                        ovf = 1'b1;
                    end
                end
            end
            wr_ptr_q   <= wp;
            count_q    <= cnt;
            o_overflow <= ovf;
        end
    end

    // Read address advances one entry per pop.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared table lookup and history output.

    logic [EVLOG_MSG_LEN_W-1:0] tbl_len;   // Looked-up text length.
    evlog_qent_t                stage_q;   // Entry under lookup.
    logic                       looked_q;  // Table data now valid.

    // Each instance holds its own copy of the table; writes are broadcast to all.
    // The read is addressed by the staged entry, not by the queue head: the
    // head moves on at the pop, while the staged identifier stays put for
    // the whole lookup, so the length shown belongs to the entry shown.
    evlog_msg_table u_table (
        .i_core_clk (i_core_clk),
        .i_wr       (i_tbl_wr),
        .i_rd_id    (stage_q.msg_id),
        .o_rd_len   (tbl_len)
    );

    // Lookup stage: hold the entry while the table read completes.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            out_busy_q <= 1'b0;
            looked_q   <= 1'b0;
            stage_q    <= '0;
        end else if (pop) begin
            out_busy_q <= 1'b1;
            looked_q   <= 1'b0;
            stage_q    <= q_mem_q[rd_ptr_q];
        end else if (out_busy_q && !looked_q) begin
            looked_q <= 1'b1;
        end else if (o_hist_valid && i_hist_ready) begin
            out_busy_q <= 1'b0;
            looked_q   <= 1'b0;
        end
    end

    // Present the entry; a lower-index instance with pending work wins.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_hist_valid <= 1'b0;
            o_hist_entry <= '0;
        end else if (o_hist_valid && i_hist_ready) begin
            o_hist_valid <= 1'b0;
        end else if (looked_q && !o_hist_valid && !i_lower_busy) begin
            o_hist_valid <= 1'b1;
            o_hist_entry <= '{EVLOG_BLK_W'(BLK_INDEX), stage_q.input_n,
                              stage_q.msg_id, tbl_len};
        end
    end

    // Pending-work flag for higher-index instances.
    // Fresh hits count too, so a higher block is held off from the cycle after
    // this block's edges arrive, the same cycle in which they reach the queue.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (count_q != '0) || out_busy_q || (hit != '0);
        end
    end

endmodule

// File: verif/evlog_props.sv
`timescale 1ns/1ns
// Port checker for one logger instance.
module evlog_props
    import evlog_pkg::*;
#(
    parameter int NUM_INPUTS = EVLOG_MAX_INPUTS, // Used inputs.
    parameter int BLK_INDEX  = 0                 // Instance index.
) (
    input wire logic                          i_core_clk,   // Clock.
    input wire logic                          i_reset,      // Reset.
    input wire logic [NUM_INPUTS-1:0]         i_sig,        // Inputs.
    input wire evlog_edge_t [NUM_INPUTS-1:0]  i_edge_cfg,   // Edges.
    input wire logic [NUM_INPUTS-1:0][EVLOG_MSG_ID_W-1:0] i_msg_cfg, // IDs.
    input wire evlog_tbl_wr_t                 i_tbl_wr,     // Table write.
    input wire logic                          i_hist_ready, // Accepts.
    input wire logic                          i_lower_busy, // Lower busy.
    input wire logic [NUM_INPUTS-1:0]         o_pulse,      // Pulses.
    input wire logic                          o_hist_valid, // Offered.
    input wire evlog_entry_t                  o_hist_entry, // Entry.
    input wire logic                          o_busy,       // Pending.
    input wire logic                          o_overflow    // Dropped.
);
    logic [1:0] age_q; // Cycles since reset, saturating at two.

    // Counts the settling cycles that follow each reset.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) age_q <= 2'h0;
        else if (age_q != 2'h2) age_q <= age_q + 2'h1;
    end

    // Works out which inputs saw a qualifying transition.
    function automatic logic [NUM_INPUTS-1:0] hits(
        input logic [NUM_INPUTS-1:0] now, input logic [NUM_INPUTS-1:0] old,
        input evlog_edge_t [NUM_INPUTS-1:0] cfg);
        for (int k = 0; k < NUM_INPUTS; k++) begin
            hits[k] = (now[k] & ~old[k] & cfg[k][0])
                    | (~now[k] & old[k] & cfg[k][1]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // An edge arrives while the instance is fully idle.
    sequence first_hit; (!o_busy && !o_hist_valid) ##1 (|o_pulse); endsequence
    // No lower instance holds the store for three cycles.
    sequence lower_idle3; !i_lower_busy [*3]; endsequence

    pulse_match_a: assert property (age_q == 2'h2 |-> o_pulse ==
        hits($past(i_sig), $past(i_sig, 2), $past(i_edge_cfg)))
        else $error("pulse differs from input edges");
    no_spurious_a: assert property (age_q != 2'h2 |-> o_pulse == '0)
        else $error("pulse right after reset");
    entry_hold_a: assert property (o_hist_valid && !i_hist_ready |=>
        o_hist_valid && $stable(o_hist_entry)) else $error("entry not held");
    entry_gap_a: assert property (o_hist_valid && i_hist_ready |=>
        !o_hist_valid [*2]) else $error("entry not retired");
    blk_index_a: assert property (o_hist_valid |->
        o_hist_entry.blk == 8'(BLK_INDEX)) else $error("wrong block index");
    msg_id_a: assert property (o_hist_valid |-> o_hist_entry.msg_id ==
        i_msg_cfg[o_hist_entry.input_n]) else $error("wrong message id");
    lower_first_a: assert property (i_lower_busy && !o_hist_valid |=>
        !o_hist_valid) else $error("entry offered past lower block");
    entry_latency_a: assert property (first_hit ##0 lower_idle3 |=>
        o_hist_valid) else $error("entry late");
    busy_on_hit_a: assert property (|o_pulse |-> o_busy)
        else $error("edge without busy");
    overflow_busy_a: assert property (o_overflow |-> o_busy)
        else $error("overflow while empty");
    reset_quiet_a: assert property (disable iff (1'b0) i_reset |=>
        o_pulse == '0 && !o_hist_valid && !o_busy && !o_overflow)
        else $error("output active after reset");
endmodule

bind evlog_logger evlog_props #(.NUM_INPUTS(NUM_INPUTS),
    .BLK_INDEX(BLK_INDEX)) u_evlog_props (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_sig(i_sig), .i_edge_cfg(i_edge_cfg),
    .i_msg_cfg(i_msg_cfg), .i_tbl_wr(i_tbl_wr), .i_hist_ready(i_hist_ready),
    .i_lower_busy(i_lower_busy), .o_pulse(o_pulse),
    .o_hist_valid(o_hist_valid), .o_hist_entry(o_hist_entry),
    .o_busy(o_busy), .o_overflow(o_overflow));

// File: verif/evlog_hist_store.sv
`timescale 1ns/1ns
// Diagnostics history store model: records every accepted entry.
module evlog_hist_store
    import evlog_pkg::*;
(
    input  wire logic         i_core_clk, // Clock.
    input  wire logic         i_stall,    // Bench asks for a slow store.
    input  wire logic         i_valid,    // Entry offered.
    input  wire evlog_entry_t i_entry,    // Entry data.
    output logic              o_ready     // Store accepts.
);
    evlog_entry_t got[$]; // Entries taken, oldest first.
    initial o_ready = 1'b0;
    // Ready moves at the falling edge, well away from sampling.
    always @(negedge i_core_clk) o_ready <= !i_stall;
    // An entry counts at the rising edge where valid meets ready.
    always @(posedge i_core_clk) begin
        if (i_valid && o_ready) got.push_back(i_entry);
    end
endmodule

// File: verif/tb_evlog_logger.sv
`timescale 1ns/1ns
module tb_evlog_logger
    import evlog_pkg::*;
;
    localparam int BLK = 5;                      // Instance index used.
    logic              core_clk = 1'b0;          // Clock.
    logic              reset    = 1'b1;          // Reset.
    logic [7:0]        sig      = 8'h00;         // Monitored inputs.
    evlog_edge_t [7:0] edge_cfg = '{default: EVLOG_EDGE_BOTH}; // Edges.
    logic [7:0][5:0]   msg_cfg;                  // Message ids.
    evlog_tbl_wr_t     tbl_wr   = '0;            // Table write.
    logic              lower_busy = 1'b0;        // Lower block pending.
    logic              stall    = 1'b0;          // Store stall request.
    logic              ovf_seen = 1'b0;          // Overflow was seen.
    logic [7:0]        pulse;                    // Edge pulses.
    logic              hist_valid, hist_ready, busy, overflow; // Status.
    evlog_entry_t      hist_entry;               // Offered entry.
    int                err_count = 0;            // Mismatches.
    int                cmp_count = 0;            // Comparisons.

    // Free-running 125 MHz clock.
    initial forever #4 core_clk = ~core_clk;
    // Remembers a drop pulse; read mid-cycle, where the flag is settled.
    always @(negedge core_clk) if (overflow === 1'b1) ovf_seen = 1'b1;

    evlog_logger #(.NUM_INPUTS(8), .BLK_INDEX(BLK)) u_evlog_logger (
        .i_core_clk(core_clk), .i_reset(reset), .i_sig(sig),
        .i_edge_cfg(edge_cfg), .i_msg_cfg(msg_cfg), .i_tbl_wr(tbl_wr),
        .i_hist_ready(hist_ready), .i_lower_busy(lower_busy),
        .o_pulse(pulse), .o_hist_valid(hist_valid),
        .o_hist_entry(hist_entry), .o_busy(busy), .o_overflow(overflow));
    evlog_hist_store u_evlog_hist_store (.i_core_clk(core_clk),
        .i_stall(stall), .i_valid(hist_valid), .i_entry(hist_entry),
        .o_ready(hist_ready));

    ////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Counts one comparison and reports it when it fails.
    task ck(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t value mismatch", $time);
        end
    endtask
    // Length stored for each identifier; the last one is the longest.
    function automatic logic [14:0] len_of(input int id);
        return (id == 63) ? 15'h7FFF : 15'(id) + 15'h0100;
    endfunction
    task end_of_test;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Fills all 64 shared entries through the common write port.
    task t_table;
        for (int k = 0; k < 64; k++) begin
            tbl_wr <= '{1'b1, 6'(k), len_of(k)};
            tick(1);
        end
        tbl_wr <= '0;
        tick(2);
    endtask
    // Every edge code against a rise then a fall on the even inputs.
    task t_edges;
        for (int c = 0; c < 4; c++) begin
            for (int v = 0; v < 2; v++) begin
                for (int i = 0; i < 8; i++) edge_cfg[i] <= evlog_edge_t'(c);
                sig <= v ? 8'h00 : 8'h55;
                // The pulse stands from the next rising edge to the one after.
                tick(1);
                ck(pulse === (c[v] ? 8'h55 : 8'h00));
                tick(1);
                ck(pulse === 8'h00);
                tick(30);
            end
        end
    endtask
    // All inputs fire at once while the store stalls.
    task t_order;
        u_evlog_hist_store.got.delete();
        stall <= 1'b1;
        sig <= 8'hFF;
        tick(12);
        stall <= 1'b0;
        for (int w = 0; w < 200 && u_evlog_hist_store.got.size() < 8; w++)
            tick(1);
        ck(u_evlog_hist_store.got.size() == 8);
        for (int k = 0; k < 8; k++) begin
            ck(u_evlog_hist_store.got[k] ===
                {8'(BLK), 3'(k), 6'(k * 9), len_of(k * 9)});
        end
        sig <= 8'h00;
        tick(60);
    endtask
    // A busy lower block holds us back while the queue overfills.
    task t_lower;
        lower_busy <= 1'b1;
        sig <= 8'hFF;
        tick(2);
        sig <= 8'h00;
        tick(30);
        ck(hist_valid === 1'b0);
        ck(ovf_seen === 1'b1);
        lower_busy <= 1'b0;
        tick(80);
        ck(busy === 1'b0);
    endtask

    initial begin
        for (int k = 0; k < 8; k++) msg_cfg[k] = 6'(k * 9);
        tick(2);
        reset <= 1'b0;
        t_table();
        t_edges();
        t_order();
        t_lower();
        end_of_test();
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule
